// >>> core/ssl_lamp_top.sv
// Status lamp controller with teach-in sequencing and APB registers
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ssl_lamp_top #(
  parameter int CLK_PER_MS = ssl_pkg::CLK_PER_MS,
  parameter int TEACH_MS = ssl_pkg::TEACH_MS,
  parameter int COMMIT_MS = ssl_pkg::COMMIT_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic act_present,
  input wire logic act_new,
  input wire logic act_wrong,
  input wire logic safe_in1,
  input wire logic safe_in2,
  input wire logic sup_out_tol,
  input wire logic sup_edge_tol,
  input wire logic out_fault,
  input wire logic int_fault,
  input wire logic start_fail,
  input wire logic [3:0] learn_left_nv,
  input wire logic learn_pend_nv,
  output logic [3:0] learn_left,
  output logic learn_pend,
  output logic dev_green,
  output logic dev_red,
  output logic dev_yellow,
  output logic gate_yellow,
  output logic input_yellow,
  output logic irq
);
  localparam int DW = $clog2(CLK_PER_MS);
  localparam int TW = $clog2(COMMIT_MS + 1);
  localparam int LW = ssl_pkg::LEARN_W;
  localparam int EW = ssl_pkg::EV_W;

  typedef struct packed {
    ssl_pkg::ssl_state_t st;
    logic [DW-1:0] div;
    logic tick;
    logic [TW-1:0] tmr;
    logic [LW-1:0] left;
    logic pend;
    logic loaded;
    logic teach_en;
    logic [EW-1:0] istat;
    logic [EW-1:0] ien;
    logic [31:0] rdata;
    logic slverr;
    logic rdy;
    logic irq;
    logic green;
    logic red;
    logic yellow;
    logic gate;
    logic inl;
  } ssl_state_vec_t;

  ssl_state_vec_t s_q, s_d;
  logic slow_b, quick_b, vquick_b;

  // Three cadences share the millisecond tick
  ssl_blink #(.ON_MS(ssl_pkg::SLOW_ON_MS), .OFF_MS(ssl_pkg::SLOW_OFF_MS))
    u_slow (.pclk(pclk), .presetn(presetn), .ms_tick(s_q.tick),
            .blink_q(slow_b));
  ssl_blink #(.ON_MS(ssl_pkg::QUICK_ON_MS), .OFF_MS(ssl_pkg::QUICK_OFF_MS))
    u_quick (.pclk(pclk), .presetn(presetn), .ms_tick(s_q.tick),
             .blink_q(quick_b));
  ssl_blink #(.ON_MS(ssl_pkg::VQUICK_ON_MS), .OFF_MS(ssl_pkg::VQUICK_OFF_MS))
    u_vquick (.pclk(pclk), .presetn(presetn), .ms_tick(s_q.tick),
              .blink_q(vquick_b));

  logic setup, wr;
  logic [EW-1:0] ev;
  logic overlay;

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    ev = '0;
    overlay = start_fail || sup_out_tol || sup_edge_tol;

    // Millisecond divider
    s_d.tick = 1'b0;
    if (s_q.div == DW'(CLK_PER_MS - 1)) begin
      s_d.div = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 1'b1;
    end

    // Allowance restored after power-up; a pending teach completes here
    if (!s_q.loaded) begin
      s_d.loaded = 1'b1;
      s_d.left = learn_left_nv;
      s_d.pend = 1'b0;
      if (learn_pend_nv && learn_left_nv != '0) begin
        s_d.left = learn_left_nv - 1'b1;
      end
    end

    // Operating sequence; latched faults win over everything else
    if (s_q.tick) begin
      s_d.tmr = s_q.tmr + 1'b1;
    end
    unique case (s_q.st)
      ssl_pkg::ST_NORM: begin
        s_d.tmr = '0;
        if (s_q.loaded && act_new && act_present && s_q.teach_en &&
            !overlay && s_q.left != '0) begin
          s_d.st = ssl_pkg::ST_TEACH;
          ev[ssl_pkg::EV_TEACH] = 1'b1;
        end
      end
      ssl_pkg::ST_TEACH: begin
        if (!act_present) begin
          s_d.st = ssl_pkg::ST_NORM; // Removed actuator aborts teaching
        end else if (s_q.tick && s_q.tmr == TW'(TEACH_MS - 1)) begin
          s_d.st = ssl_pkg::ST_TAUGHT;
          s_d.tmr = '0;
          s_d.pend = 1'b1;
          ev[ssl_pkg::EV_TAUGHT] = 1'b1;
        end
      end
      ssl_pkg::ST_TAUGHT: begin
        if (s_q.tick && s_q.tmr == TW'(COMMIT_MS - 1)) begin
          s_d.st = ssl_pkg::ST_NORM;
          s_d.pend = 1'b0;
          s_d.tmr = '0;
        end
      end
      ssl_pkg::ST_OUTF: s_d.st = ssl_pkg::ST_OUTF;
      ssl_pkg::ST_INTERR: s_d.st = ssl_pkg::ST_INTERR;
      default: s_d.st = ssl_pkg::ST_NORM;
    endcase
    if (int_fault) begin
      s_d.st = ssl_pkg::ST_INTERR;
    end else if (out_fault && s_q.st != ssl_pkg::ST_INTERR) begin
      s_d.st = ssl_pkg::ST_OUTF;
      ev[ssl_pkg::EV_OUTF] = s_q.st != ssl_pkg::ST_OUTF;
    end
    if (s_d.st == ssl_pkg::ST_OUTF || s_d.st == ssl_pkg::ST_INTERR) begin
      s_d.pend = 1'b0; // A faulty unit never commits a teach
    end
    ev[ssl_pkg::EV_SUPPLY] = sup_out_tol || sup_edge_tol;

    // Lamp patterns, highest priority first
    s_d.green = 1'b1;
    s_d.red = 1'b0;
    s_d.yellow = 1'b0;
    s_d.gate = act_present;
    if (safe_in1 && safe_in2) begin
      s_d.inl = 1'b1;
    end else if (!safe_in1 && !safe_in2) begin
      s_d.inl = 1'b0;
    end
    if (s_q.st == ssl_pkg::ST_INTERR) begin
      s_d.green = 1'b0;
      s_d.red = 1'b1;
      s_d.gate = 1'b0;
      s_d.inl = 1'b0;
    end else if (start_fail) begin
      s_d.green = 1'b0;
      s_d.gate = slow_b;
      s_d.inl = slow_b;
    end else if (s_q.st == ssl_pkg::ST_OUTF) begin
      s_d.green = 1'b0;
      s_d.red = slow_b;
      s_d.gate = s_q.gate;
      s_d.inl = s_q.inl;
    end else if (sup_out_tol) begin
      s_d.green = 1'b0;
      s_d.red = quick_b;
      s_d.gate = slow_b;
      s_d.inl = slow_b;
    end else if (sup_edge_tol) begin
      s_d.green = 1'b0;
      s_d.yellow = slow_b;
      s_d.gate = 1'b0;
      s_d.inl = 1'b0;
    end else if (s_q.st == ssl_pkg::ST_TEACH) begin
      s_d.gate = slow_b;
    end else if (s_q.st == ssl_pkg::ST_TAUGHT) begin
      s_d.gate = vquick_b;
    end else if (act_wrong) begin
      s_d.gate = vquick_b;
    end

    // Register writes take effect in the access phase
    if (wr && paddr == ssl_pkg::REG_CTRL) begin
      s_d.teach_en = pwdata[ssl_pkg::CTRL_TEACH_EN];
    end
    if (wr && paddr == ssl_pkg::REG_IRQ_EN) begin
      s_d.ien = pwdata[EW-1:0];
    end
    // New events win over a clear in the same cycle
    s_d.istat = s_q.istat;
    if (wr && paddr == ssl_pkg::REG_IRQ_CLR) begin
      s_d.istat = s_q.istat & ~pwdata[EW-1:0];
    end
    s_d.istat = s_d.istat | ev;
    s_d.irq = |(s_d.istat & s_d.ien);

    // Zero wait states: ready from the first edge after reset
    s_d.rdy = 1'b1;
    // Error flag stands for the single access cycle only
    s_d.slverr = 1'b0;
    // Read data prepared in setup so pready can stay high
    if (setup) begin
      s_d.rdata = '0;
      s_d.slverr = 1'b0;
      unique case (paddr)
        ssl_pkg::REG_CTRL: s_d.rdata[ssl_pkg::CTRL_TEACH_EN] = s_q.teach_en;
        ssl_pkg::REG_STATUS: begin
          s_d.rdata[4:0] = s_q.st;
          s_d.rdata[ssl_pkg::STAT_LEFT_LSB +: LW] = s_q.left;
          s_d.rdata[ssl_pkg::STAT_PEND] = s_q.pend;
        end
        ssl_pkg::REG_IRQ_STAT: s_d.rdata[EW-1:0] = s_q.istat;
        ssl_pkg::REG_IRQ_CLR: s_d.rdata = '0;
        ssl_pkg::REG_IRQ_EN: s_d.rdata[EW-1:0] = s_q.ien;
        default: s_d.slverr = 1'b1;
      endcase
    end
  end

  // Single register stage for all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{st: ssl_pkg::ST_NORM, div: '0, tick: 1'b0, tmr: '0,
               left: '0, pend: 1'b0, loaded: 1'b0,
               teach_en: ssl_pkg::CTRL_RST, istat: '0,
               ien: ssl_pkg::IRQ_EN_RST, rdata: '0, slverr: 1'b0,
               irq: 1'b0, green: 1'b0, red: 1'b0, yellow: 1'b0,
               gate: 1'b0, inl: 1'b0, rdy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign pready = s_q.rdy;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr;
  assign learn_left = s_q.left;
  assign learn_pend = s_q.pend;
  assign dev_green = s_q.green;
  assign dev_red = s_q.red;
  assign dev_yellow = s_q.yellow;
  assign gate_yellow = s_q.gate;
  assign input_yellow = s_q.inl;
  assign irq = s_q.irq;

  localparam int ONE = 1;
  sequence teach_done_s;
    s_q.st == ssl_pkg::ST_TEACH && act_present && !int_fault &&
      !out_fault && s_q.tick && s_q.tmr == TW'(TEACH_MS - 1);
  endsequence
  sequence taught_s;
    s_q.st == ssl_pkg::ST_TAUGHT && s_q.pend && s_q.tmr == '0;
  endsequence

  teach_span_a: assert property (@(posedge pclk) disable iff (!presetn)
    teach_done_s |=> taught_s)
    else $error("teach phase did not end after its time");
  commit_win_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == ssl_pkg::ST_TAUGHT && s_q.tick && !int_fault &&
     !out_fault && s_q.tmr == TW'(COMMIT_MS - 1))
    |=> s_q.st == ssl_pkg::ST_NORM && !s_q.pend)
    else $error("commit window not closed");
  learn_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(s_q.loaded) && $past(learn_pend_nv) && $past(learn_left_nv) != '0)
    |-> learn_left == $past(learn_left_nv) - 4'h1)
    else $error("teach allowance not reduced");
  no_teach_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == ssl_pkg::ST_NORM && s_q.left == '0)
    |=> s_q.st != ssl_pkg::ST_TEACH)
    else $error("teach entered with no allowance");
  int_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    int_fault |=> ##[ONE:2] (dev_red && !dev_green && !gate_yellow &&
      !input_yellow))
    else $error("internal error lamps wrong");
  freeze_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == ssl_pkg::ST_OUTF && !int_fault && !start_fail) [*2]
    |=> $stable(gate_yellow) && $stable(input_yellow) && !dev_green)
    else $error("fault lamps not frozen");
  fault_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == ssl_pkg::ST_OUTF |=> s_q.st != ssl_pkg::ST_NORM)
    else $error("output fault left without power cycle");
  norm_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.loaded && s_q.st == ssl_pkg::ST_NORM && !overlay && !int_fault &&
     !act_wrong)
    |=> dev_green && gate_yellow == $past(act_present))
    else $error("normal lamps wrong");
  input_lamp_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.loaded && s_q.st == ssl_pkg::ST_NORM && !overlay && !int_fault &&
     !out_fault && safe_in1 == safe_in2) |=> input_yellow == $past(safe_in1))
    else $error("input lamp does not follow inputs");
  supply_pri_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.loaded && sup_out_tol &&
     s_q.st inside {ssl_pkg::ST_NORM, ssl_pkg::ST_TEACH}
     && !int_fault && !out_fault && !start_fail)
    |=> !dev_green && gate_yellow == $past(slow_b))
    else $error("supply fault pattern not shown");
  irq_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((sup_out_tol || sup_edge_tol) && s_q.ien[ssl_pkg::EV_SUPPLY] &&
     !(wr && paddr == ssl_pkg::REG_IRQ_EN))
    |=> irq && s_q.istat[ssl_pkg::EV_SUPPLY])
    else $error("supply event not flagged");
endmodule : ssl_lamp_top
`default_nettype wire

// >>> core/ssl_pkg.sv
// Constants, types and register map of the safety switch status lamp logic
package ssl_pkg;
  // Clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CLK_PER_MS = CLK_HZ / MS_PER_S;

  // Blink cadences in ms
  localparam int SLOW_ON_MS = 500;
  localparam int SLOW_OFF_MS = 500;
  localparam int QUICK_ON_MS = 50;
  localparam int QUICK_OFF_MS = 950;
  localparam int VQUICK_ON_MS = 30;
  localparam int VQUICK_OFF_MS = 470;

  // Teach timing in seconds and derived ms
  localparam int TEACH_S = 20;
  localparam int COMMIT_S = 120;
  localparam int TEACH_MS = TEACH_S * MS_PER_S;
  localparam int COMMIT_MS = COMMIT_S * MS_PER_S;

  // Lifetime teach allowance
  localparam int LEARN_MAX = 8;
  localparam int LEARN_W = 4;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN = 8'h10;

  // Field positions and reset values
  localparam int CTRL_TEACH_EN = 0;
  localparam logic CTRL_RST = 1'h1;
  localparam int STAT_LEFT_LSB = 8;
  localparam int STAT_PEND = 12;
  localparam int EV_W = 4;
  localparam int EV_TEACH = 0;
  localparam int EV_TAUGHT = 1;
  localparam int EV_OUTF = 2;
  localparam int EV_SUPPLY = 3;
  localparam logic [EV_W-1:0] IRQ_EN_RST = 4'h0;

  // Operating states, one-hot
  typedef enum logic [4:0] {
    ST_NORM = 5'h01,
    ST_TEACH = 5'h02,
    ST_TAUGHT = 5'h04,
    ST_OUTF = 5'h08,
    ST_INTERR = 5'h10
  } ssl_state_t;
endpackage : ssl_pkg

// >>> core/ssl_blink.sv
// One lamp blink cadence generator driven by a millisecond tick
`timescale 1ns/1ps
`default_nettype none
module ssl_blink #(
  parameter int ON_MS = 500,
  parameter int OFF_MS = 500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ms_tick,
  output logic blink_q
);
  localparam int PER = ON_MS + OFF_MS;
  localparam int CW = $clog2(PER);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic blink;
  } ssl_blink_t;

  ssl_blink_t s_q, s_d;

  // Phase counter; lamp lit in the first ON_MS of each period
  always_comb begin
    s_d = s_q;
    if (ms_tick) begin
      if (s_q.cnt == CW'(PER - 1)) begin
        s_d.cnt = '0;
        s_d.blink = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == CW'(ON_MS - 1)) begin
          s_d.blink = 1'b0;
        end
      end
    end
  end

  // Starts lit so a pattern is visible at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{cnt: '0, blink: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign blink_q = s_q.blink;

  blink_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ms_tick && s_q.cnt == CW'(ON_MS - 1)) |=> !blink_q)
    else $error("lamp not dark after lit time");
  blink_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ms_tick && s_q.cnt == CW'(PER - 1)) |=> blink_q && s_q.cnt == '0)
    else $error("lamp not lit at period start");
endmodule : ssl_blink
`default_nettype wire

// >>> sim/ssl_nv_store.sv
// Nonvolatile store that keeps the teach allowance across power cycles
`timescale 1ns/1ps
`default_nettype none
module ssl_nv_store #(
  parameter logic [3:0] LEFT_INIT = 4'h8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] learn_left,
  input wire logic learn_pend,
  output logic [3:0] learn_left_nv,
  output logic learn_pend_nv
);
  logic up_q;
  // Factory state of the store
  initial begin
    learn_left_nv = LEFT_INIT;
    learn_pend_nv = 1'h0;
  end
  // Save only once the device has loaded, so reset zeros never land
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q <= 1'h0;
    end else begin
      up_q <= 1'h1;
      if (up_q) begin
        learn_left_nv <= learn_left;
        learn_pend_nv <= learn_pend;
      end
    end
  end
endmodule : ssl_nv_store
`default_nettype wire

// >>> sim/ssl_lamp_top_bench.sv
// Self-checking bench for the status lamp controller
`timescale 1ns/1ps
`default_nettype none
module ssl_lamp_top_bench;
  localparam int CPM = 4;
  localparam int TMS = 5;
  localparam int CMS = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic act_present, act_new, act_wrong, safe_in1, safe_in2;
  logic sup_out_tol, sup_edge_tol, out_fault, int_fault, start_fail;
  logic [3:0] learn_left_nv, learn_left;
  logic learn_pend_nv, learn_pend, irq;
  logic dev_green, dev_red, dev_yellow, gate_yellow, input_yellow;
  logic [4:0] lamps;
  int bad_count = 0;
  int n_checks = 0;
  // Rows: present, in1, in2 then green, gate, input; disagreeing inputs hold
  logic [5:0] rows [6] = '{6'h04, 6'h3F, 6'h37, 6'h26, 6'h14, 6'h1D};
  assign lamps = {input_yellow, gate_yellow, dev_yellow, dev_red, dev_green};
  ssl_lamp_top #(.CLK_PER_MS(CPM), .TEACH_MS(TMS), .COMMIT_MS(CMS)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .act_present(act_present),
    .act_new(act_new), .act_wrong(act_wrong), .safe_in1(safe_in1),
    .safe_in2(safe_in2), .sup_out_tol(sup_out_tol),
    .sup_edge_tol(sup_edge_tol), .out_fault(out_fault),
    .int_fault(int_fault), .start_fail(start_fail),
    .learn_left_nv(learn_left_nv), .learn_pend_nv(learn_pend_nv),
    .learn_left(learn_left), .learn_pend(learn_pend),
    .dev_green(dev_green), .dev_red(dev_red), .dev_yellow(dev_yellow),
    .gate_yellow(gate_yellow), .input_yellow(input_yellow), .irq(irq));
  ssl_nv_store nv (
    .pclk(pclk), .presetn(presetn), .learn_left(learn_left),
    .learn_pend(learn_pend), .learn_left_nv(learn_left_nv),
    .learn_pend_nv(learn_pend_nv));
  // 25 MHz clock
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic clk(input int n);
    repeat (n) @(posedge pclk);
  endtask : clk
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (k == 50) begin
      bad_count++;
      test_done;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Counting over one whole period gives the lit time whatever the phase
  task automatic cnt(input int idx, input int per, input int exp,
      input string msg);
    int n;
    n = 0;
    repeat (per) begin
      @(posedge pclk);
      if (lamps[idx] === 1'h1) n++;
    end
    chk(n, exp, msg);
  endtask : cnt
  task automatic do_reset;
    presetn <= 1'h0;
    clk(4);
    presetn <= 1'h1;
    clk(2);
  endtask : do_reset
  // Hang guard
  initial begin
    clk(100000);
    bad_count++;
    test_done;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {act_present, act_new, act_wrong, safe_in1, safe_in2} = '0;
    {sup_out_tol, sup_edge_tol, out_fault, int_fault, start_fail} = '0;
    clk(4);
    chk({pready, irq, lamps}, 7'h00, "outputs in reset");
    presetn <= 1'h1;
    clk(2);
    apb(1'h0, ssl_pkg::REG_CTRL, 32'h0);
    chk({err, rd[30:0]}, 32'h1, "ctrl reset");
    apb(1'h0, ssl_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h801, "status reset");
    apb(1'h0, 8'h14, 32'h0);
    chk(err, 1'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    for (int r = 0; r < 6; r++) begin
      {act_present, safe_in1, safe_in2} <= rows[r][5:3];
      clk(3);
      chk({dev_green, gate_yellow}, rows[r][2:1], "normal lamps");
      chk(input_yellow, rows[r][0], "input lamp");
    end
    sup_edge_tol <= 1'h1;
    clk(3);
    cnt(2, 4000, 2000, "edge slow yellow");
    apb(1'h1, ssl_pkg::REG_IRQ_EN, 32'h8);
    sup_out_tol <= 1'h1;
    clk(3);
    chk(irq, 1'h1, "irq raised");
    cnt(1, 4000, 200, "out quick red");
    cnt(3, 4000, 2000, "out gate slow");
    cnt(4, 4000, 2000, "out input slow");
    sup_out_tol <= 1'h0;
    sup_edge_tol <= 1'h0;
    apb(1'h1, ssl_pkg::REG_IRQ_CLR, 32'h8);
    clk(3);
    chk(irq, 1'h0, "irq cleared");
    apb(1'h1, ssl_pkg::REG_IRQ_EN, 32'h0);
    sup_out_tol <= 1'h1;
    clk(3);
    chk(irq, 1'h0, "irq masked");
    sup_out_tol <= 1'h0;
    apb(1'h0, ssl_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd[3], 1'h1, "sticky status");
    {act_wrong, act_present} <= 2'h3;
    clk(3);
    chk(dev_green, 1'h1, "wrong green");
    cnt(3, 2000, 120, "wrong gate vquick");
    act_wrong <= 1'h0;
    {safe_in1, safe_in2} <= 2'h3;
    clk(3);
    out_fault <= 1'h1;
    clk(3);
    {out_fault, act_present, safe_in1, safe_in2} <= 4'h0;
    clk(3);
    chk({input_yellow, gate_yellow}, 2'h3, "frozen lamps");
    cnt(1, 4000, 2000, "fault red slow");
    apb(1'h0, ssl_pkg::REG_STATUS, 32'h0);
    chk(rd[4:0], 5'h08, "fault held");
    do_reset;
    {int_fault, sup_out_tol, act_present, safe_in1, safe_in2} <= 5'h1F;
    clk(3);
    int_fault <= 1'h0;
    clk(3);
    chk(lamps, 5'h02, "internal fault");
    {sup_out_tol, act_present, safe_in1, safe_in2} <= 4'h0;
    do_reset;
    // Teach gate closed, start failure shown, then a lapsed commit window
    apb(1'h1, ssl_pkg::REG_CTRL, 32'h0);
    {act_present, act_new, start_fail} <= 3'h7;
    clk(3);
    chk(lamps[2:0], 3'h0, "start fail device off");
    cnt(4, 4000, 2000, "start fail input slow");
    start_fail <= 1'h0;
    clk(3);
    apb(1'h0, ssl_pkg::REG_STATUS, 32'h0);
    chk(rd[4:0], 5'h01, "teach disabled");
    apb(1'h1, ssl_pkg::REG_CTRL, 32'h1);
    clk(2);
    act_new <= 1'h0;
    clk((TMS + CMS) * CPM + 12);
    apb(1'h0, ssl_pkg::REG_STATUS, 32'h0);
    chk(rd[12:0], 13'h0801, "commit window lapsed");
    apb(1'h0, ssl_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd[3:0], 4'h3, "teach events");
    act_present <= 1'h0;
    do_reset;
    chk(learn_left, 8, "lapsed teach keeps allowance");
    for (int i = 0; i < 9; i++) begin
      {act_present, act_new} <= 2'h3;
      clk(4);
      apb(1'h0, ssl_pkg::REG_STATUS, 32'h0);
      chk(rd[4:0], (i < 8) ? 5'h02 : 5'h01, "teach entry");
      chk(dev_green, 1'h1, "teach green");
      if (i < 8) begin
        clk(TMS * CPM + 8);
        apb(1'h0, ssl_pkg::REG_STATUS, 32'h0);
        chk({dev_green, rd[4:0]}, 6'h24, "taught");
        chk(learn_pend, 1'h1, "pending");
      end
      {act_present, act_new} <= 2'h0;
      do_reset;
      chk(learn_left, (i < 8) ? 7 - i : 0, "allowance");
    end
    test_done;
  end
endmodule : ssl_lamp_top_bench
`default_nettype wire
